/* rtl/serial_flash_command_sequencer.sv */
// Overview of operation
// - clear-status resets erase-error bit 4 and program-error bit 3 and sets done bit 7
// - failing operation sets error flags; they stay until clear-status
// - program and erase commands refused while any error flag is set
// - identification: opcode, dummy byte, then maker and part codes out
// - sector erase takes A22..A16 and starts at chip-select rise
// - status and identification reads still answered while busy
// - one to 128 data bytes load into page buffer until chip select rises
// - a partial final data byte is discarded
// - buffer pointer wraps from last page byte to first
// - chip-select rise after page load starts programming that page
// - standby while chip select high and no operation running
// - power-up status: done bit 7 one, errors zero, ready bit 0 one
// - reset pin low long enough aborts, floats outputs, ignores commands
// - hardware reset returns sequencer to array-reading state
// - serial input and output bits move on serial clock rising edge
// - every byte travels most significant bit first
// - address bytes carry A22..A17, A16..A9, A8..A7, A6..A0
// - status bit 0 reads one when ready, zero while busy
// - bit 7 falls on completion, rises on new program, erase or clear
// - sector erase opcode is F1h
// - clear-status opcode is 89h, serial output floats during it
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_sequencer
    import flash_seq_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A,  // arbitrary value
    parameter logic [7:0] PART_CODE = 8'hA5,   // arbitrary value
    parameter logic [31:0] PROG_CYCLES = 32'h0007_A120,
    parameter logic [31:0] SECTOR_CYCLES = 32'h0100_0000,
    parameter logic [31:0] CHIP_CYCLES = 32'h1000_0000
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    input wire logic reset_n_i,
    output logic so_o,
    output logic so_oe_o,
    // array engine
    output logic op_start_o,
    output op_kind_type op_kind_o,
    output logic [ADDR_W-1:0] op_addr_o,
    input wire logic op_fail_i,
    input wire logic [PTR_W-1:0] buf_raddr_i,
    output logic [7:0] buf_rdata_o,
    // state
    output logic [7:0] status_o,
    output logic busy_o,
    output logic standby_o
);
    pins_type pins_raw;
    pins_type pins_s;
    logic sclk_prev_q;
    logic cs_prev_q;
    logic [RST_CNT_W-1:0] rst_cnt_q;
    logic hw_reset_q;
    state_type state_q;
    logic [7:0] cmd_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [2:0] bit_cnt_q;
    logic [2:0] byte_cnt_q;
    logic id_sel_q;
    logic [PTR_W-1:0] ptr_q;
    logic data_seen_q;
    logic [7:0] page_buf [PAGE_BYTES];
    logic done_q;
    logic erase_err_q;
    logic prog_err_q;
    logic timer_busy;
    logic timer_done;
    logic [31:0] op_len;

    assign pins_raw = '{reset_n: reset_n_i, cs_n: cs_n_i, sclk: sclk_i, si: si_i};

    pin_sync #(
        .W($bits(pins_type)),
        .RST_VAL(PINS_IDLE)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic byte_done;
    logic [7:0] rx_d;
    logic err_any;
    logic is_out_cmd;
    logic is_op_cmd;
    logic out_load;
    logic clear_cmd;
    logic start_ok;
    logic start_prog;
    logic start_erase;
    logic [7:0] status_d;

    assign sclk_rise = pins_s.sclk && !sclk_prev_q && !pins_s.cs_n && !hw_reset_q
                       && state_q != ST_READ_ARRAY_IDLE;
    assign cs_fall = !pins_s.cs_n && cs_prev_q;
    assign cs_rise = pins_s.cs_n && !cs_prev_q;
    assign rx_d = {rx_q[6:0], pins_s.si};
    assign byte_done = sclk_rise && bit_cnt_q == BIT_LAST;
    assign err_any = erase_err_q || prog_err_q;
    assign is_out_cmd = cmd_q == OP_READ_STATUS || cmd_q == OP_READ_ID;
    assign is_op_cmd = rx_d == OP_SECTOR_ERASE || rx_d == OP_CHIP_ERASE
                       || rx_d == OP_PAGE_PROGRAM;
    assign clear_cmd = byte_done && state_q == ST_OPCODE && rx_d == OP_CLEAR_STATUS;
    assign out_load = byte_done && is_out_cmd
                      && (state_q == ST_OUT || (state_q == ST_ADDR && byte_cnt_q == BYTE_AD1));
    assign start_ok = cs_rise && !hw_reset_q && !timer_busy && !err_any;
    assign start_prog = start_ok && state_q == ST_DATA && data_seen_q;
    assign start_erase = start_ok && state_q == ST_ARMED;
    assign op_len = (cmd_q == OP_PAGE_PROGRAM) ? PROG_CYCLES
                  : (cmd_q == OP_SECTOR_ERASE) ? SECTOR_CYCLES : CHIP_CYCLES;

    op_timer #(
        .W(32)
    ) u_op_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(start_prog || start_erase),
        .len_i(op_len),
        .abort_i(hw_reset_q),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= pins_s.sclk;
            cs_prev_q <= pins_s.cs_n;
        end
    end

    // reset pin must stay low a full pulse width before it takes effect
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_cnt_q <= '0;
            hw_reset_q <= 1'b0;
        end else if (pins_s.reset_n) begin
            rst_cnt_q <= '0;
            hw_reset_q <= 1'b0;
        end else if (rst_cnt_q == RST_CNT_W'(RESET_PULSE_CYCLES - 1)) begin
            hw_reset_q <= 1'b1;
        end else begin
            rst_cnt_q <= rst_cnt_q + RST_CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_READ_ARRAY_IDLE;
            cmd_q <= 8'h00;
            rx_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= BYTE_OPCODE;
        end else if (hw_reset_q || cs_rise) begin
            state_q <= ST_READ_ARRAY_IDLE;
        end else if (cs_fall) begin
            state_q <= ST_OPCODE;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= BYTE_OPCODE;
        end else if (sclk_rise) begin
            rx_q <= rx_d;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done && byte_cnt_q != BYTE_DATA) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
            if (byte_done) begin
                case (state_q)
                    ST_OPCODE: begin
                        cmd_q <= rx_d;
                        if (rx_d == OP_READ_STATUS || rx_d == OP_READ_ID) begin
                            state_q <= ST_ADDR;
                        end else if (is_op_cmd && !err_any && !timer_busy) begin
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    ST_ADDR: begin
                        if (is_out_cmd) begin
                            state_q <= ST_OUT;
                        end else if (cmd_q != OP_PAGE_PROGRAM && byte_cnt_q == BYTE_AD2) begin
                            state_q <= ST_ARMED;
                        end else if (cmd_q == OP_PAGE_PROGRAM && byte_cnt_q == BYTE_BA) begin
                            state_q <= ST_DATA;
                        end
                    end
                    ST_DATA, ST_OUT, ST_ARMED, ST_IGNORE: begin
                        state_q <= state_q;
                    end
                    default: begin
                        state_q <= ST_IGNORE;
                    end
                endcase
            end
        end
    end

    // address capture; bits outside the layout are dropped
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_addr_o <= '0;
        end else if (byte_done && state_q == ST_ADDR && !is_out_cmd) begin
            case (byte_cnt_q)
                BYTE_AD1: op_addr_o[ADDR_W-1:ADDR_W-1-AD1_MSB] <= rx_d[AD1_MSB:0];
                BYTE_AD2: op_addr_o[ADDR_W-2-AD1_MSB:PAGE_LSB+AD3_MSB+1] <= rx_d;
                BYTE_AD3: op_addr_o[PAGE_LSB+AD3_MSB:PAGE_LSB] <= rx_d[AD3_MSB:0];
                BYTE_BA: op_addr_o[BA_MSB:0] <= rx_d[BA_MSB:0];
                default: op_addr_o <= op_addr_o;
            endcase
        end
    end

    // page buffer load; only whole bytes are written
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_q <= '0;
            data_seen_q <= 1'b0;
        end else if (cs_fall) begin
            data_seen_q <= 1'b0;
        end else if (byte_done && state_q == ST_ADDR && byte_cnt_q == BYTE_BA) begin
            ptr_q <= rx_d[BA_MSB:0];
        end else if (byte_done && state_q == ST_DATA) begin
            ptr_q <= ptr_q + PTR_W'(1);
            data_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (byte_done && state_q == ST_DATA) begin
            page_buf[ptr_q] <= rx_d;
        end
        buf_rdata_o <= page_buf[buf_raddr_i];
    end

    // output shifter: bit changes on the same rising edge the host shifts on
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_q <= 8'h00;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
            id_sel_q <= 1'b0;
        end else if (hw_reset_q || pins_s.cs_n || cs_rise) begin
            so_oe_o <= 1'b0;
            id_sel_q <= 1'b0;
        end else if (out_load) begin
            so_oe_o <= 1'b1;
            if (cmd_q == OP_READ_STATUS) begin
                tx_q <= {status_d[6:0], 1'b0};
                so_o <= status_d[7];
            end else begin
                tx_q <= {(id_sel_q ? PART_CODE[6:0] : MAKER_CODE[6:0]), 1'b0};
                so_o <= id_sel_q ? PART_CODE[7] : MAKER_CODE[7];
                id_sel_q <= !id_sel_q;
            end
        end else if (sclk_rise && state_q == ST_OUT) begin
            so_o <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_start_o <= 1'b0;
            op_kind_o <= OPK_PROGRAM;
        end else begin
            op_start_o <= start_prog || start_erase;
            if (start_prog) begin
                op_kind_o <= OPK_PROGRAM;
            end else if (start_erase) begin
                op_kind_o <= (cmd_q == OP_SECTOR_ERASE) ? OPK_SECTOR : OPK_CHIP;
            end
        end
    end

    // completion falls on a finished operation; that event wins over a clear
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            done_q <= ST_DONE_RST;
            erase_err_q <= ST_ERR_RST;
            prog_err_q <= ST_ERR_RST;
        end else begin
            if (timer_done) begin
                done_q <= 1'b0;
            end else if (start_prog || start_erase || clear_cmd) begin
                done_q <= 1'b1;
            end
            if (timer_done && op_fail_i && op_kind_o != OPK_PROGRAM) begin
                erase_err_q <= 1'b1;
            end else if (clear_cmd) begin
                erase_err_q <= 1'b0;
            end
            if (timer_done && op_fail_i && op_kind_o == OPK_PROGRAM) begin
                prog_err_q <= 1'b1;
            end else if (clear_cmd) begin
                prog_err_q <= 1'b0;
            end
        end
    end

    always_comb begin
        status_d = 8'h00;
        status_d[ST_DONE_BIT] = done_q;
        status_d[ST_ERASE_ERR_BIT] = erase_err_q;
        status_d[ST_PROG_ERR_BIT] = prog_err_q;
        // ready waits for the flags to settle so a poll never sees ready with stale flags
        status_d[ST_READY_BIT] = !timer_busy && !timer_done;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            status_o <= 8'h81;
            busy_o <= 1'b0;
            standby_o <= 1'b1;
        end else begin
            status_o <= status_d;
            busy_o <= timer_busy;
            standby_o <= pins_s.cs_n && !timer_busy;
        end
    end

    property p_clear_flags;
        @(posedge mclk_i) disable iff (rst_i)
        clear_cmd && !timer_done |=> !erase_err_q && !prog_err_q && done_q;
    endproperty
    a_clear_flags: assert property (p_clear_flags) else $error("clear left flags");

    property p_err_sticky;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(erase_err_q) || $fell(prog_err_q) |-> $past(clear_cmd);
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

    property p_refuse;
        @(posedge mclk_i) disable iff (rst_i)
        op_start_o |-> !$past(err_any) && !$past(timer_busy);
    endproperty
    a_refuse: assert property (p_refuse) else $error("operation started with error set");

    property p_erase_start;
        @(posedge mclk_i) disable iff (rst_i)
        start_erase |=> op_start_o && op_kind_o != OPK_PROGRAM ##1 busy_o && !status_o[0];
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase did not start");

    property p_wrap;
        @(posedge mclk_i) disable iff (rst_i)
        byte_done && state_q == ST_DATA && ptr_q == PTR_W'(PAGE_BYTES - 1) |=> ptr_q == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_standby;
        @(posedge mclk_i) disable iff (rst_i)
        ##1 standby_o == ($past(pins_s.cs_n) && $past(timer_busy) == 1'b0);
    endproperty
    a_standby: assert property (p_standby) else $error("standby mismatch");

    property p_hw_reset;
        @(posedge mclk_i) disable iff (rst_i)
        hw_reset_q |=> !so_oe_o && state_q == ST_READ_ARRAY_IDLE ##1 !busy_o [*2];
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("reset pin not obeyed");

    property p_done_fall;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(done_q) |-> $past(timer_done) ##1 !status_o[ST_DONE_BIT];
    endproperty
    a_done_fall: assert property (p_done_fall) else $error("completion bit fell early");

    property p_oe_only_out;
        @(posedge mclk_i) disable iff (rst_i)
        so_oe_o |-> !$past(pins_s.cs_n) && (state_q == ST_OUT) && is_out_cmd;
    endproperty
    a_oe_only_out: assert property (p_oe_only_out) else $error("output driven off read");

endmodule : serial_flash_command_sequencer
`default_nettype wire

/* rtl/flash_seq_pkg.sv */
package flash_seq_pkg;

    // command opcodes
    localparam logic [7:0] OP_READ_ARRAY = 8'h52;
    localparam logic [7:0] OP_READ_STATUS = 8'h83;
    localparam logic [7:0] OP_CLEAR_STATUS = 8'h89;
    localparam logic [7:0] OP_READ_ID = 8'h85;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hF1;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hF4;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'hF2;

    // operation_status_flags bit positions and power-on values
    localparam int ST_DONE_BIT = 7;
    localparam int ST_ERASE_ERR_BIT = 4;
    localparam int ST_PROG_ERR_BIT = 3;
    localparam int ST_READY_BIT = 0;
    localparam logic ST_DONE_RST = 1'b1;
    localparam logic ST_ERR_RST = 1'b0;

    // address byte layout
    localparam int ADDR_W = 23;
    localparam int AD1_MSB = 5;
    localparam int AD3_MSB = 1;
    localparam int BA_MSB = 6;
    localparam int PAGE_LSB = 7;
    localparam int SECTOR_LSB = 16;
    localparam int PAGE_BYTES = 128;
    localparam int PTR_W = 7;

    // byte positions within a frame
    localparam logic [2:0] BYTE_OPCODE = 3'h0;
    localparam logic [2:0] BYTE_AD1 = 3'h1;
    localparam logic [2:0] BYTE_AD2 = 3'h2;
    localparam logic [2:0] BYTE_AD3 = 3'h3;
    localparam logic [2:0] BYTE_BA = 3'h4;
    localparam logic [2:0] BYTE_DATA = 3'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // reset pin pulse width
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_PULSE_NS = 500;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 7;

    typedef enum logic [2:0] {
        ST_READ_ARRAY_IDLE = 3'h0,
        ST_OPCODE = 3'h1,
        ST_ADDR = 3'h3,
        ST_DATA = 3'h2,
        ST_OUT = 3'h6,
        ST_ARMED = 3'h7,
        ST_IGNORE = 3'h5
    } state_type;

    typedef enum logic [1:0] {
        OPK_PROGRAM = 2'h0,
        OPK_SECTOR = 2'h1,
        OPK_CHIP = 2'h2
    } op_kind_type;

    typedef struct packed {
        logic reset_n;
        logic cs_n;
        logic sclk;
        logic si;
    } pins_type;

    localparam pins_type PINS_IDLE = 4'hC;

endpackage : flash_seq_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // pins in, filtered levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    s1_q[i] <= RST_VAL[i];
                    s2_q[i] <= RST_VAL[i];
                    s3_q[i] <= RST_VAL[i];
                    q_o[i] <= RST_VAL[i];
                end else begin
                    s1_q[i] <= d_i[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // a change counts only once two stages agree
                    if (s2_q[i] == s3_q[i]) begin
                        q_o[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

/* rtl/op_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module op_timer #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // control
    input wire logic start_i,
    input wire logic [W-1:0] len_i,
    input wire logic abort_i,
    // status
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            done_o <= 1'b0;
        end else if (abort_i) begin
            cnt_q <= '0;
            done_o <= 1'b0;
        end else if (start_i && cnt_q == '0) begin
            cnt_q <= (len_i == '0) ? {{(W-1){1'b0}}, 1'b1} : len_i;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign busy_o = (cnt_q != '0);
endmodule : op_timer
`default_nettype wire

/* verif/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // clock
    input wire logic mclk_i,
    // serial pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    logic last_q;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
        last_q = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : wait_clk
    // sclk idles low between frames, 20 mclk per bit
    task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx,
                         output logic oe);
        rx = 8'h00;
        oe = 1'b1;
        for (int i = 7; i > 7 - nbits; i--) begin
            si_o = tx[i];
            wait_clk(10);
            sclk_o = 1'b1;
            // a floating line reads as the inverse of the last bit, never a stale copy
            rx[i] = so_oe_i ? so_i : ~last_q;
            last_q = rx[i];
            oe = oe & so_oe_i;
            wait_clk(10);
            sclk_o = 1'b0;
        end
    endtask : shift
    task automatic frame_start();
        cs_n_o = 1'b0;
        wait_clk(8);
    endtask : frame_start
    task automatic frame_end();
        wait_clk(10);
        cs_n_o = 1'b1;
        wait_clk(10);
    endtask : frame_end
endmodule : spi_host_model
`default_nettype wire

/* verif/serial_flash_command_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_sequencer_tb;
    import flash_seq_pkg::*;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [7:0] PART = 8'hC3; // arbitrary value
    logic mclk, rst, reset_n, fail, cs_n, sclk, si, so, so_oe, start, busy, standby, oe;
    op_kind_type kind, s_kind;
    logic [ADDR_W-1:0] addr, s_addr;
    logic [PTR_W-1:0] raddr;
    logic [7:0] rdata, status, r;
    logic [7:0] rx[$];
    logic oex[$];
    int n_fail, cmp_count, n_start;
    serial_flash_command_sequencer #(.MAKER_CODE(MAKER), .PART_CODE(PART),
        .PROG_CYCLES(32'h800), .SECTOR_CYCLES(32'h800), .CHIP_CYCLES(32'h800))
    serial_flash_command_sequencer_i (.mclk_i(mclk), .rst_i(rst), .cs_n_i(cs_n),
        .sclk_i(sclk), .si_i(si), .reset_n_i(reset_n), .so_o(so), .so_oe_o(so_oe),
        .op_start_o(start), .op_kind_o(kind), .op_addr_o(addr), .op_fail_i(fail),
        .buf_raddr_i(raddr), .buf_rdata_o(rdata), .status_o(status), .busy_o(busy),
        .standby_o(standby));
    spi_host_model spi_host_model_i (.mclk_i(mclk), .cs_n_o(cs_n), .sclk_o(sclk),
        .si_o(si), .so_i(so), .so_oe_i(so_oe));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (start === 1'b1) begin
            n_start++;
            s_kind = kind;
            s_addr = addr;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic frame(input logic [7:0] tx[$], input int tail);
        rx = {};
        oex = {};
        spi_host_model_i.frame_start();
        foreach (tx[k]) begin
            spi_host_model_i.shift(tx[k], 8, r, oe);
            rx.push_back(r);
            oex.push_back(oe);
        end
        if (tail > 0) begin
            spi_host_model_i.shift(8'hFF, tail, r, oe);
        end
        spi_host_model_i.frame_end();
    endtask : frame
    task automatic wait_ready();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            cyc(1);
            n++;
        end
        if (n >= 5000) begin
            n_fail++;
            $display("CHECK FAILED busy expected 0 seen %b", busy);
            print_verdict();
        end
        // flags and ready settle a cycle after busy falls
        cyc(3);
    endtask : wait_ready
    task automatic t_power_on();
        check("status", 8'h81, status);
        check("standby", 1, standby);
        check("so_oe", 0, so_oe);
    endtask : t_power_on
    task automatic t_read_id();
        frame({OP_READ_ID, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
        check("id oe dummy", 0, oex[1]);
        check("id oe", 1, oex[2]);
        check("maker", MAKER, rx[2]);
        check("part", PART, rx[3]);
        check("maker again", MAKER, rx[4]);
    endtask : t_read_id
    task automatic t_program();
        logic [7:0] tx[$];
        tx = {OP_PAGE_PROGRAM, 8'h3F, 8'h81, 8'h02, 8'h00};
        for (int k = 0; k < 129; k++) begin
            tx.push_back(8'(k + 16));
        end
        fail = 1'b1;
        frame(tx, 5);
        cyc(10);
        check("prog start", 1, n_start);
        check("prog kind", OPK_PROGRAM, s_kind);
        check("prog addr", {6'h3F, 8'h81, 2'h2, 7'h00}, s_addr);
        frame({OP_READ_STATUS, 8'h00, 8'h00}, 0);
        check("busy status", 8'h80, rx[2]);
        raddr = 7'h00;
        cyc(2);
        check("buf 0", 8'h90, rdata);
        raddr = 7'h01;
        cyc(2);
        check("buf 1", 8'h11, rdata);
        raddr = 7'h7F;
        cyc(2);
        check("buf 127", 8'h8F, rdata);
        wait_ready();
        check("prog fail", 8'h09, status);
    endtask : t_program
    task automatic t_refuse_clear();
        frame({OP_SECTOR_ERASE, 8'h2A, 8'hC3}, 0);
        cyc(10);
        check("refused", 1, n_start);
        frame({OP_CLEAR_STATUS, 8'h00}, 0);
        check("clear oe", 0, oex[0]);
        check("cleared", 8'h81, status);
    endtask : t_refuse_clear
    task automatic t_erase();
        frame({OP_SECTOR_ERASE, 8'h2A, 8'hC3}, 0);
        cyc(10);
        check("sec start", 2, n_start);
        check("sec kind", OPK_SECTOR, s_kind);
        check("sector", 7'h55, s_addr[22:16]);
        wait_ready();
        check("erase fail", 8'h11, status);
        frame({OP_CLEAR_STATUS, 8'h00}, 0);
        fail = 1'b0;
        frame({OP_CHIP_ERASE, 8'h00, 8'h00}, 0);
        cyc(10);
        check("chip kind", OPK_CHIP, s_kind);
        reset_n = 1'b0;
        cyc(80);
        check("hw oe", 0, so_oe);
        check("hw busy", 0, busy);
        check("hw standby", 1, standby);
        reset_n = 1'b1;
        cyc(70);
        check("hw status", 8'h81, status);
        frame({OP_CHIP_ERASE, 8'h00, 8'h00}, 0);
        frame({OP_READ_ID, 8'h00, 8'h00}, 0);
        check("busy id", MAKER, rx[2]);
        check("chip start", 4, n_start);
        wait_ready();
        check("chip done", 8'h01, status);
    endtask : t_erase
    initial begin
        rst = 1'b1;
        reset_n = 1'b1;
        fail = 1'b0;
        raddr = '0;
        n_fail = 0;
        cmp_count = 0;
        n_start = 0;
        cyc(16);
        rst = 1'b0;
        cyc(8);
        t_power_on();
        t_read_id();
        t_program();
        t_refuse_clear();
        t_erase();
        print_verdict();
    end
endmodule : serial_flash_command_sequencer_tb
`default_nettype wire
